// File: spisp_pkg.sv
/*
 * Constants shared by the slave serial port: register byte offsets,
 * field positions, reset values and mode encodings.
 * Assumes a 32-bit classic Wishbone register bus, one word per register.
 */
package spisp_pkg;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [7:0] SPISP_OFS_CTRL     = 8'h00;
    localparam logic [7:0] SPISP_OFS_STATUS   = 8'h04;
    localparam logic [7:0] SPISP_OFS_BUF      = 8'h08;
    localparam logic [7:0] SPISP_OFS_PINSEL   = 8'h0C;
    localparam logic [7:0] SPISP_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] SPISP_OFS_IRQ_MASK = 8'h14;

    // ********************************************************
    // serial_port_control fields
    // ********************************************************
    localparam int SPISP_CTRL_COLL = 7;
    localparam int SPISP_CTRL_OVF  = 6;
    localparam int SPISP_CTRL_EN   = 5;
    localparam int SPISP_CTRL_CPOL = 4;
    localparam int SPISP_CTRL_MODE = 0;
    localparam logic [7:0] SPISP_CTRL_RESET = 8'h00;

    // ********************************************************
    // serial_port_status fields
    // ********************************************************
    localparam int SPISP_STAT_PHASE = 7;
    localparam int SPISP_STAT_CKE   = 6;
    localparam int SPISP_STAT_FULL  = 0;
    localparam logic [7:0] SPISP_STAT_RESET = 8'h00;

    // ********************************************************
    // Pin location and interrupt fields
    // ********************************************************
    localparam int SPISP_PINSEL_LOC = 0;
    localparam int SPISP_IRQ_DONE   = 0;
    localparam int SPISP_IRQ_WRITE_COLLISION_FLAG   = 1;
    localparam int SPISP_IRQ_OVF    = 2;
    localparam logic [2:0] SPISP_IRQ_RESET = 3'h0;

    // ********************************************************
    // port_mode_field encodings handled by this block
    // ********************************************************
    localparam logic [3:0] SPISP_MODE_SLAVE_SEL   = 4'h4;
    localparam logic [3:0] SPISP_MODE_SLAVE_NOSEL = 4'h5;

    localparam logic [3:0] SPISP_BITS_PER_BYTE = 4'h8;

endpackage : spisp_pkg

// File: spisp_shift_if.sv
/*
 * Signals between the register side of the slave port and its
 * shift engine. Both ends run on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface spisp_shift_if;
    logic       lead;
    logic       trail;
    logic       serial_in_pin;
    logic       cke;
    logic       hold;
    logic       load;
    logic [7:0] load_data;
    logic       serial_out_pin;
    logic       busy;
    logic       done;
    logic [7:0] rx_byte;

    modport ctrl (
        output lead, trail, serial_in_pin, cke, hold, load, load_data,
        input  serial_out_pin, busy, done, rx_byte
    );
    modport eng (
        input  lead, trail, serial_in_pin, cke, hold, load, load_data,
        output serial_out_pin, busy, done, rx_byte
    );
endinterface : spisp_shift_if

`default_nettype wire

// File: spisp_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level relative to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module spisp_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    // Levels
    input  wire logic [W-1:0] i_async,
    output var  logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : spisp_sync

`default_nettype wire

// File: spisp_shift.sv
/*
 * Shift engine: 8-bit shift register, bit counter and output bit.
 * Assumes lead and trail are one-cycle edge strobes of the serial
 * clock, found by the caller from a synchronised copy.
 */
`timescale 1ns/1ps
`default_nettype none

module spisp_shift
    import spisp_pkg::*;
(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst_b,
    // Control side
    spisp_shift_if.eng bus
);
    logic [7:0] sr_reg;
    logic [3:0] cnt_reg;
    logic       rxb_reg;
    logic       out_reg;
    logic       busy_reg;
    logic       done_reg;
    logic [7:0] rx_reg;

    wire        sample   = bus.cke ? bus.trail : bus.lead;
    wire        shift    = bus.cke ? bus.lead : bus.trail;
    wire        last_bit = (cnt_reg == SPISP_BITS_PER_BYTE - 4'h1);
    wire [7:0]  rx_next  = {sr_reg[6:0], bus.serial_in_pin};

    assign bus.serial_out_pin     = bus.cke ? out_reg : sr_reg[7];
    assign bus.busy    = busy_reg;
    assign bus.done    = done_reg;
    assign bus.rx_byte = rx_reg;

    // ********************************************************
    // Counter and handshake
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || bus.hold) begin
            cnt_reg  <= 4'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= sample && last_bit;
            if (sample && last_bit) begin
                cnt_reg  <= 4'h0;
                busy_reg <= 1'b0;
            end else if (sample) begin
                cnt_reg  <= cnt_reg + 4'h1;
                busy_reg <= 1'b1;
            end else if (shift && bus.cke) begin
                busy_reg <= 1'b1;
            end
        end
    end

    // ********************************************************
    // Data path, runs on serial clock edges and on buffer loads
    // ********************************************************
    // Shift register keeps its contents over a hold; software reloads
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sr_reg  <= 8'h00;
            rxb_reg <= 1'b0;
            out_reg <= 1'b0;
            rx_reg  <= 8'h00;
        end else if (bus.load) begin
            sr_reg  <= bus.load_data;
            out_reg <= bus.load_data[7];
        end else if (!bus.hold) begin
            if (sample && last_bit) begin
                rx_reg <= rx_next;
            end
            if (bus.cke && sample) begin
                sr_reg <= rx_next;
            end else if (!bus.cke && sample) begin
                rxb_reg <= bus.serial_in_pin;
            end else if (!bus.cke && shift) begin
                sr_reg <= {sr_reg[6:0], rxb_reg};
            end else if (bus.cke && shift) begin
                out_reg <= sr_reg[7];
            end
        end
    end
endmodule : spisp_shift

`default_nettype wire

// File: spisp_top.sv
/*
 * Slave-mode synchronous serial port with optional slave select,
 * registers on classic Wishbone, sticky interrupt status and mask.
 * Assumes the external master supplies the serial clock and select;
 * all pins are asynchronous to i_clk and pass two flip-flops first.
 */
`timescale 1ns/1ps
`default_nettype none

module spisp_top
    import spisp_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output var  logic [31:0] o_wb_dat,
    output var  logic        o_wb_ack,
    // Serial pins
    input  wire logic        i_sck,
    input  wire logic        i_sdi,
    input  wire logic        i_ss_main_b,
    input  wire logic        i_ss_alt_b,
    output var  logic        o_sdo,
    output var  logic        o_sdo_oe,
    output var  logic        o_sck_oe,
    output var  logic        o_pins_owned,
    // Interrupt
    output var  logic        o_irq
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [3:0] pins_s;

    spisp_sync #(
        .W (4)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async ({i_ss_alt_b, i_ss_main_b, i_sdi, i_sck}),
        .o_sync  (pins_s)
    );

    wire sck_s     = pins_s[0];
    wire sdi_s     = pins_s[1];
    wire ss_main_s = pins_s[2];
    wire ss_alt_s  = pins_s[3];

    // ********************************************************
    // Registers
    // ********************************************************
    logic       coll_reg;
    logic       ovf_reg;
    logic       en_reg;
    logic       cpol_reg;
    logic [3:0] mode_reg;
    logic       phase_reg;
    logic       cke_reg;
    logic       full_reg;
    logic [7:0] rxbuf_reg;
    logic       loc_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic       sck_d_reg;
    logic [31:0] rdat_next;

    // ********************************************************
    // Mode and select decoding
    // ********************************************************
    wire mode_sel   = (mode_reg == SPISP_MODE_SLAVE_SEL);
    wire mode_nosel = (mode_reg == SPISP_MODE_SLAVE_NOSEL);
    wire active     = en_reg && (mode_sel || mode_nosel);
    wire ss_pin     = loc_reg ? ss_alt_s : ss_main_s;
    wire ss_ctl     = en_reg && mode_sel;
    // Without select control the pin level never reaches the engine
    wire ss_high    = ss_ctl && ss_pin;
    wire ss_low     = ss_ctl && !ss_pin;
    wire sdo_drive  = active && (ss_low || mode_nosel);
    // Overflow freezes the engine until software clears it
    wire hold       = !active || ss_high || ovf_reg;

    function automatic logic clk_edge(input logic prev, input logic cur,
                                      input logic idle, input logic lead);
        clk_edge = lead ? (prev == idle) && (cur != idle)
                        : (prev != idle) && (cur == idle);
    endfunction : clk_edge

    // ********************************************************
    // Shift engine
    // ********************************************************
    spisp_shift_if sh ();

    assign sh.lead      = clk_edge(sck_d_reg, sck_s, cpol_reg, 1'b1);
    assign sh.trail     = clk_edge(sck_d_reg, sck_s, cpol_reg, 1'b0);
    assign sh.serial_in_pin       = sdi_s;
    assign sh.cke       = cke_reg;
    assign sh.hold      = hold;

    spisp_shift u_shift (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .bus     (sh.ctrl)
    );

    // ********************************************************
    // Wishbone decode
    // ********************************************************
    // Ack one cycle after the request; effects at the acked edge
    wire req     = i_wb_cyc && i_wb_stb;
    wire take    = req && o_wb_ack;
    wire wr      = take && i_wb_we && i_wb_sel[0];
    wire rd      = take && !i_wb_we;
    wire a_ctrl  = (i_wb_adr == SPISP_OFS_CTRL);
    wire a_stat  = (i_wb_adr == SPISP_OFS_STATUS);
    wire a_buf   = (i_wb_adr == SPISP_OFS_BUF);
    wire a_loc   = (i_wb_adr == SPISP_OFS_PINSEL);
    wire a_istat = (i_wb_adr == SPISP_OFS_IRQ_STAT);
    wire a_imask = (i_wb_adr == SPISP_OFS_IRQ_MASK);
    wire [7:0] wd = i_wb_dat[7:0];

    wire wr_buf   = wr && a_buf;
    wire collide  = wr_buf && sh.busy;
    wire rd_buf   = rd && a_buf;
    wire rx_ok    = sh.done && !full_reg;
    wire rx_ovf   = sh.done && full_reg;

    assign sh.load      = wr_buf && !sh.busy;
    assign sh.load_data = wd;

    wire [7:0] ctrl_val = {coll_reg, ovf_reg, en_reg, cpol_reg, mode_reg};
    wire [7:0] stat_val = {phase_reg, cke_reg, 5'h00, full_reg};
    wire [2:0] irq_ev   = {rx_ovf, collide, sh.done};

    always_comb begin
        rdat_next = 32'h0000_0000;
        if (a_ctrl) begin
            rdat_next[7:0] = ctrl_val;
        end else if (a_stat) begin
            rdat_next[7:0] = stat_val;
        end else if (a_buf) begin
            rdat_next[7:0] = rxbuf_reg;
        end else if (a_loc) begin
            rdat_next[SPISP_PINSEL_LOC] = loc_reg;
        end else if (a_istat) begin
            rdat_next[2:0] = irq_stat_reg;
        end else if (a_imask) begin
            rdat_next[2:0] = irq_mask_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= req && !o_wb_ack;
            o_wb_dat <= rdat_next;
        end
    end

    // ********************************************************
    // Control and status registers
    // ********************************************************
    // Flags set by hardware win over a software clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            {coll_reg, ovf_reg, en_reg, cpol_reg, mode_reg}
                <= SPISP_CTRL_RESET;
        end else begin
            if (wr && a_ctrl) begin
                en_reg   <= wd[SPISP_CTRL_EN];
                cpol_reg <= wd[SPISP_CTRL_CPOL];
                mode_reg <= wd[SPISP_CTRL_MODE +: 4];
            end
            coll_reg <= collide ||
                (coll_reg && !(wr && a_ctrl && !wd[SPISP_CTRL_COLL]));
            ovf_reg  <= rx_ovf ||
                (ovf_reg && !(wr && a_ctrl && !wd[SPISP_CTRL_OVF]));
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            {phase_reg, cke_reg} <= SPISP_STAT_RESET[7:6];
            full_reg  <= SPISP_STAT_RESET[SPISP_STAT_FULL];
            rxbuf_reg <= 8'h00;
            loc_reg   <= 1'b0;
        end else begin
            if (wr && a_stat) begin
                phase_reg <= wd[SPISP_STAT_PHASE];
                cke_reg <= wd[SPISP_STAT_CKE];
            end
            if (wr && a_loc) begin
                loc_reg <= wd[SPISP_PINSEL_LOC];
            end
            if (rx_ok) begin
                rxbuf_reg <= sh.rx_byte;
            end
            full_reg <= rx_ok || rx_ovf || (full_reg && !rd_buf);
        end
    end

    // ********************************************************
    // Interrupt status and mask
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            irq_stat_reg <= SPISP_IRQ_RESET;
            irq_mask_reg <= SPISP_IRQ_RESET;
            o_irq        <= 1'b0;
        end else begin
            if (wr && a_imask) begin
                irq_mask_reg <= wd[2:0];
            end
            irq_stat_reg <= irq_ev |
                ((rd && a_istat) ? 3'h0 : irq_stat_reg);
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ********************************************************
    // Pin outputs
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sck_d_reg    <= 1'b0;
            o_sdo        <= 1'b0;
            o_sdo_oe     <= 1'b0;
            o_sck_oe     <= 1'b0;
            o_pins_owned <= 1'b0;
        end else begin
            sck_d_reg    <= sck_s;
            o_sdo        <= sh.serial_out_pin;
            o_sdo_oe     <= sdo_drive;
            o_sck_oe     <= 1'b0;
            o_pins_owned <= active;
        end
    end

endmodule : spisp_top

`default_nettype wire

// File: spisp_sva.sv
/* Checker for the slave serial port; sees only the ports of spisp_top.
   Assumes it is bound into spisp_top and that the bus is classic Wishbone. */
`timescale 1ns/1ps
`default_nettype none
module spisp_sva
    import spisp_pkg::*;
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    // Bus and pins
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        i_ss_main_b,
    input wire logic        i_ss_alt_b,
    input wire logic        o_sdo_oe,
    input wire logic        o_sck_oe,
    input wire logic        o_pins_owned,
    input wire logic        o_irq
);
    // ****************************************
    // Shadow of configuration written on the bus
    // ****************************************
    logic       en_reg;
    logic [3:0] mode_reg;
    logic       loc_reg;
    logic [2:0] cfg_age_reg;
    logic [2:0] ss_age_reg;
    wire logic wr = o_wb_ack && i_wb_cyc && i_wb_we && i_wb_sel[0];
    wire logic wr_ctrl = wr && i_wb_adr == SPISP_OFS_CTRL;
    wire logic wr_pin = wr && i_wb_adr == SPISP_OFS_PINSEL;
    wire logic ss_hi = loc_reg ? i_ss_alt_b : i_ss_main_b;
    wire logic owned = en_reg && (mode_reg == SPISP_MODE_SLAVE_SEL
                                  || mode_reg == SPISP_MODE_SLAVE_NOSEL);
    // Ages saturate so long idle spans stay cheap to check
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            en_reg <= 1'b0;
            mode_reg <= 4'h0;
            loc_reg <= 1'b0;
            cfg_age_reg <= 3'h0;
            ss_age_reg <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                en_reg <= i_wb_dat[SPISP_CTRL_EN];
                mode_reg <= i_wb_dat[3:0];
            end
            if (wr_pin) loc_reg <= i_wb_dat[SPISP_PINSEL_LOC];
            cfg_age_reg <= (wr_ctrl || wr_pin) ? 3'h0
                : cfg_age_reg + {2'h0, cfg_age_reg != 3'h7};
            ss_age_reg <= ss_hi ? ss_age_reg + {2'h0, ss_age_reg != 3'h7}
                : 3'h0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ****************************************
    // Assertions
    // ****************************************
    a_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack) else $error("ack missing after request");
    a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    a_read_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_sck_is_input: assert property (!o_sck_oe)
        else $error("serial clock driven");
    a_owned_by_mode: assert property (cfg_age_reg >= 3'h2
        |-> o_pins_owned == owned) else $error("pin ownership wrong");
    a_select_floats: assert property (en_reg
        && mode_reg == SPISP_MODE_SLAVE_SEL && ss_age_reg == 3'h7
        && cfg_age_reg == 3'h7 |-> !o_sdo_oe) else $error("sdo driven");
    a_off_stays_quiet: assert property (!owned
        && cfg_age_reg >= 3'h2 |-> !o_sdo_oe) else $error("sdo driven off");
    c_irq_rise: cover property ($rose(o_irq));
    c_sdo_drive: cover property ($rose(o_sdo_oe));
    c_read: cover property (o_wb_ack && !i_wb_we);
endmodule : spisp_sva
`default_nettype wire

// File: spisp_mst.sv
/* Behavioural serial bus master that clocks the slave port.
   Assumes the bench hands it a resolved view of the sdo wire. */
`timescale 1ns/1ps
`default_nettype none
module spisp_mst (
    // Pins towards the slave
    output var  logic o_sck,
    output var  logic o_sdi,
    output var  logic o_ss_main_b,
    output var  logic o_ss_alt_b,
    input  wire logic i_sdo_wire
);
    initial begin
        o_sck = 1'b0;
        o_sdi = 1'b0;
        o_ss_main_b = 1'b1;
        o_ss_alt_b = 1'b1;
    end
    task automatic idle(input logic cpol);
        o_sck = cpol;
    endtask : idle
    // Clock stands still between frames; sdi flips once released
    task automatic xfer(input logic [7:0] tx, input logic cpol, cke, loc,
                        input logic sel_on, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        if (sel_on && loc) o_ss_alt_b = 1'b0;
        if (sel_on && !loc) o_ss_main_b = 1'b0;
        #300;
        for (int i = 0; i < nbits; i++) begin
            if (!cke) o_sdi = tx[7-i];
            #80 o_sck = ~cpol;
            if (cke) o_sdi = tx[7-i];
            else rx[7-i] = i_sdo_wire;
            #80 o_sck = cpol;
            if (cke) rx[7-i] = i_sdo_wire;
        end
        #300 o_ss_main_b = 1'b1;
        o_ss_alt_b = 1'b1;
        o_sdi = ~o_sdi;
    endtask : xfer
endmodule : spisp_mst
`default_nettype wire

// File: spisp_top_bench.sv
/* Self-checking bench for spisp_top with a serial master model.
   Assumes the checker is bound in from this file. */
`timescale 1ns/1ps
`default_nettype none
module spisp_top_bench;
    import spisp_pkg::*;
    logic        clk, rst_b, cyc, stb, we, cpol, cke, loc;
    logic [7:0]  adr, mtx, stx, got, keep;
    logic [3:0]  sel;
    logic [31:0] wdat, dat_o, r;
    wire logic   ack, sck, serial_in_pin, ssm, ssa, serial_out_pin, sdo_oe, sck_oe, owned, irq;
    wire logic   sdo_wire = sdo_oe ? serial_out_pin : 1'bz;
    int          n_mismatch, compares;
    spisp_top spisp_top_i (.i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(dat_o), .o_wb_ack(ack), .i_sck(sck),
        .i_sdi(serial_in_pin), .i_ss_main_b(ssm), .i_ss_alt_b(ssa), .o_sdo(serial_out_pin),
        .o_sdo_oe(sdo_oe), .o_sck_oe(sck_oe), .o_pins_owned(owned),
        .o_irq(irq));
    spisp_mst spisp_mst_i (.o_sck(sck), .o_sdi(serial_in_pin), .o_ss_main_b(ssm),
        .o_ss_alt_b(ssa), .i_sdo_wire(sdo_wire));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // Bus cycles and comparisons
    // ****************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        r = dat_o;
        {cyc, stb, we} <= 3'h0;
        @(posedge clk);
    endtask : wb
    task automatic fail(input logic [31:0] g, e);
        n_mismatch++;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    endtask : fail
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        compares++;
        if (r !== e) fail(r, e);
    endtask : chk_reg
    task automatic chk_ser(input logic [7:0] g, e);
        compares++;
        if (g !== e) fail({24'h0, g}, {24'h0, e});
    endtask : chk_ser
    task automatic chk_bit(input logic g, e);
        compares++;
        if (g !== e) fail({31'h0, g}, {31'h0, e});
    endtask : chk_bit
    function automatic logic [31:0] cv(input logic [1:0] f, input logic [3:0] m);
        return {24'h0, f, 1'b1, cpol, m};
    endfunction : cv
    task automatic tally_and_finish;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // Reference: slave byte queued at buffer write, checked at master
    task automatic one_byte(input logic sel_on, input int nb);
        stx = 8'($urandom);
        mtx = 8'($urandom);
        wb(1'b1, SPISP_OFS_BUF, {24'h0, stx});
        spisp_mst_i.xfer(mtx, cpol, cke, loc, sel_on, nb, got);
        repeat (10) @(posedge clk);
    endtask : one_byte
    task automatic full_check;
        chk_ser(got, stx);
        chk_bit(irq, 1'b1);
        chk_reg(SPISP_OFS_STATUS, {25'h0, cke, 6'h1});
        chk_reg(SPISP_OFS_IRQ_STAT, 32'h1);
        chk_reg(SPISP_OFS_BUF, {24'h0, mtx});
        chk_reg(SPISP_OFS_STATUS, {25'h0, cke, 6'h0});
    endtask : full_check
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {cyc, stb, we, adr, wdat, cpol, cke, loc} = '0;
        sel = 4'hF;
        rst_b = 1'b0;
        n_mismatch = 0;
        compares = 0;
        void'($urandom(32'h0B4261F8));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        chk_reg(SPISP_OFS_CTRL, 32'h0);
        chk_reg(SPISP_OFS_STATUS, 32'h0);
        chk_reg(8'h1C, 32'h0);
        wb(1'b1, SPISP_OFS_IRQ_MASK, 32'h7);
        for (int k = 0; k < 4; k++) begin
            {cke, cpol} = k[1:0];
            loc = k[0] ^ k[1];
            wb(1'b1, SPISP_OFS_CTRL, 32'h0);
            spisp_mst_i.idle(cpol);
            wb(1'b1, SPISP_OFS_PINSEL, {31'h0, loc});
            wb(1'b1, SPISP_OFS_STATUS, {25'h0, cke, 6'h0});
            wb(1'b1, SPISP_OFS_CTRL, cv(2'h0, 4'h4));
            chk_bit(sdo_oe, 1'b0);
            @(posedge clk);
            chk_bit(owned, 1'b1);
            one_byte(1'b1, 8);
            full_check;
        end
        one_byte(1'b1, 3);
        chk_bit(sdo_oe, 1'b0);
        one_byte(1'b1, 8);
        full_check;
        stx = 8'($urandom);
        mtx = 8'($urandom);
        wb(1'b1, SPISP_OFS_BUF, {24'h0, stx});
        fork
            spisp_mst_i.xfer(mtx, cpol, cke, loc, 1'b1, 8, got);
            begin
                #700;
                wb(1'b1, SPISP_OFS_BUF, {24'h0, ~stx});
            end
        join
        repeat (10) @(posedge clk);
        chk_ser(got, stx);
        chk_reg(SPISP_OFS_CTRL, cv(2'h2, 4'h4));
        chk_reg(SPISP_OFS_IRQ_STAT, 32'h3);
        chk_reg(SPISP_OFS_BUF, {24'h0, mtx});
        wb(1'b1, SPISP_OFS_CTRL, cv(2'h0, 4'h4));
        chk_reg(SPISP_OFS_CTRL, cv(2'h0, 4'h4));
        wb(1'b1, SPISP_OFS_IRQ_MASK, 32'h0);
        one_byte(1'b1, 8);
        keep = mtx;
        chk_bit(irq, 1'b0);
        one_byte(1'b1, 8);
        mtx = keep;
        chk_reg(SPISP_OFS_CTRL, cv(2'h1, 4'h4));
        chk_reg(SPISP_OFS_BUF, {24'h0, mtx});
        wb(1'b1, SPISP_OFS_IRQ_MASK, 32'h7);
        repeat (3) @(posedge clk);
        chk_bit(irq, 1'b1);
        chk_reg(SPISP_OFS_IRQ_STAT, 32'h5);
        repeat (3) @(posedge clk);
        chk_bit(irq, 1'b0);
        wb(1'b1, SPISP_OFS_STATUS, 32'h0);
        cke = 1'b0;
        wb(1'b1, SPISP_OFS_CTRL, cv(2'h0, 4'h5));
        one_byte(1'b0, 8);
        full_check;
        wb(1'b1, SPISP_OFS_CTRL, cv(2'h0, 4'h0));
        repeat (4) @(posedge clk);
        chk_bit(owned, 1'b0);
        sel <= 4'hE;
        wb(1'b1, SPISP_OFS_PINSEL, 32'h1);
        sel <= 4'hF;
        chk_reg(SPISP_OFS_PINSEL, 32'h0);
        tally_and_finish;
    end
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule : spisp_top_bench
bind spisp_top spisp_sva spisp_sva_i (.*);
`default_nettype wire
